/* rtl/gpio_pin_map.vh */
// Purpose: Offsets, mode codes, reset values and timing counts for the GPIO port block
// Assumes: Wishbone classic slave with 32-bit data, byte addresses
// Notes:   Mode encoding: {mode1,mode0} per pin
`ifndef GPIO_PIN_MAP_VH
`define GPIO_PIN_MAP_VH

// ==========================================
// Register offsets (byte addresses)
`define GP_OFS_LATCH     8'h00
`define GP_OFS_MODE1     8'h04
`define GP_OFS_MODE0     8'h08
`define GP_OFS_PINS      8'h0C
`define GP_OFS_PWM_SEL   8'h10
`define GP_OFS_PWM_LVL   8'h14

// ==========================================
// Mode codes {mode1,mode0}
`define GP_MODE_QUASI    2'b00
`define GP_MODE_PUSH     2'b01
`define GP_MODE_INPUT    2'b10
`define GP_MODE_OPEN     2'b11

// ==========================================
// Reset values
`define GP_RST_LATCH     8'hFF
`define GP_RST_MODE      8'h00
`define GP_RST_PWM       8'h00

// ==========================================
// Timing counts in CPU clocks
`define GP_STRONG_CLKS   2
`define GP_ACCESS_CLKS   4

`endif

/* rtl/gpio_pin_cell.v */
// Purpose: Driver control for one port pin
// Assumes: Sensed level already synchronised
// Notes:   Strong burst counter local to the pin
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pin_map.vh"

module gpio_pin_cell (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       latch_i,
  input  wire [1:0] mode_i,
  input  wire       pwm_en_i,
  input  wire       pwm_lvl_i,
  input  wire       sense_i,
  output reg        very_weak_o,
  output reg        weak_o,
  output reg        strong_o,
  output reg        pull_down_o,
  output reg        schmitt_o
);

  reg       prev_out;
  reg [1:0] burst;
  reg [1:0] eff_mode;
  reg       out_bit;
  reg [1:0] next_burst;

  // ==========================================
  // Effective mode and output bit
  always @* begin
    eff_mode = mode_i;
    out_bit  = latch_i;
    if (pwm_en_i && mode_i != `GP_MODE_INPUT) begin
      out_bit = pwm_lvl_i;
      if (mode_i == `GP_MODE_QUASI)
        eff_mode = `GP_MODE_PUSH;
    end
  end

  // ==========================================
  // Strong pull-up burst on rising output bit
  always @* begin
    next_burst = 2'd0;
    if (eff_mode == `GP_MODE_QUASI && out_bit && !prev_out)
      next_burst = 2'd`GP_STRONG_CLKS;
    else if (eff_mode == `GP_MODE_QUASI && out_bit && burst != 2'd0)
      next_burst = burst - 2'd1;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_out <= 1'b1;
      burst    <= 2'd0;
    end else begin
      prev_out <= out_bit;
      burst    <= next_burst;
    end
  end

  // ==========================================
  // Driver selection
  always @(posedge clk_i) begin
    if (rst_i) begin
      very_weak_o <= 1'b1;
      weak_o      <= 1'b1;
      strong_o    <= 1'b0;
      pull_down_o <= 1'b0;
      schmitt_o   <= 1'b0;
    end else begin
      very_weak_o <= 1'b0;
      weak_o      <= 1'b0;
      strong_o    <= 1'b0;
      pull_down_o <= 1'b0;
      schmitt_o   <= 1'b0;
      case (eff_mode)
        `GP_MODE_QUASI: begin
          very_weak_o <= out_bit;
          weak_o      <= out_bit & sense_i;
          strong_o    <= (next_burst != 2'd0);
          pull_down_o <= ~out_bit;
        end
        `GP_MODE_PUSH: begin
          strong_o    <= out_bit;
          pull_down_o <= ~out_bit;
        end
        `GP_MODE_INPUT: begin
          schmitt_o   <= 1'b1;
        end
        `GP_MODE_OPEN: begin
          pull_down_o <= ~out_bit;
        end
        default: begin
          pull_down_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // gpio_pin_cell

`default_nettype wire

/* rtl/gpio_pin_drive_modes.v */
// Purpose: Eight-pin general-purpose port with four drive modes per pin
// Assumes: Wishbone classic slave, 32-bit data, 20 MHz clock, synchronous reset
// Notes:   Pad driver controls are outputs; analog behaviour is outside
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pin_map.vh"

module gpio_pin_drive_modes #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             cyc_i,
  input  wire             stb_i,
  input  wire             we_i,
  input  wire [7:0]       adr_i,
  input  wire [3:0]       sel_i,
  input  wire [31:0]      dat_i,
  output reg  [31:0]      dat_o,
  output reg              ack_o,
  output wire             err_o,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] very_weak_o,
  output wire [WIDTH-1:0] weak_o,
  output wire [WIDTH-1:0] strong_o,
  output wire [WIDTH-1:0] pull_down_o,
  output wire [WIDTH-1:0] schmitt_o
);

  // ==========================================
  // Register state
  reg  [WIDTH-1:0] port_latch;
  reg  [WIDTH-1:0] mode_hi;
  reg  [WIDTH-1:0] mode_lo;
  reg  [WIDTH-1:0] pwm_sel;
  reg  [WIDTH-1:0] pwm_lvl;
  reg  [WIDTH-1:0] sync1;
  reg  [WIDTH-1:0] sync2;
  reg  [WIDTH-1:0] sync3;
  reg  [WIDTH-1:0] sensed;
  reg  [1:0]       wait_cnt;
  reg              busy;
  reg              hit;
  reg  [31:0]      rd_val;
  wire             req;
  wire [WIDTH-1:0] pwm_act;

  // Wait states between taking a request and raising ack
  localparam [31:0] ACK_WAIT = `GP_ACCESS_CLKS - 3;

  assign req   = cyc_i & stb_i;
  assign err_o = 1'b0;

  // ==========================================
  // Pin input synchroniser, change accepted when stages two and three agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1  <= {WIDTH{1'b1}};
      sync2  <= {WIDTH{1'b1}};
      sync3  <= {WIDTH{1'b1}};
      sensed <= {WIDTH{1'b1}};
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
      sensed <= (sync2 & sync3) | (sensed & (sync2 | sync3));
    end
  end

  // ==========================================
  // Read mux
  always @* begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (adr_i)
      `GP_OFS_LATCH:   rd_val[WIDTH-1:0] = port_latch;
      `GP_OFS_MODE1:   rd_val[WIDTH-1:0] = mode_hi;
      `GP_OFS_MODE0:   rd_val[WIDTH-1:0] = mode_lo;
      `GP_OFS_PINS:    rd_val[WIDTH-1:0] = sensed;
      `GP_OFS_PWM_SEL: rd_val[WIDTH-1:0] = pwm_sel;
      `GP_OFS_PWM_LVL: rd_val[WIDTH-1:0] = pwm_lvl;
      default:         hit = 1'b0;
    endcase
  end

  // ==========================================
  // Wishbone slave, every access takes four clocks to ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      busy     <= 1'b0;
      wait_cnt <= 2'd0;
      dat_o    <= 32'h0000_0000;
    end else begin
      ack_o <= 1'b0;
      if (req && !ack_o && !busy) begin
        busy     <= 1'b1;
        wait_cnt <= 2'd0;
      end else if (busy) begin
        if (wait_cnt == ACK_WAIT[1:0]) begin
          busy  <= 1'b0;
          ack_o <= 1'b1;
          dat_o <= hit ? rd_val : 32'h0000_0000;
        end else begin
          wait_cnt <= wait_cnt + 2'd1;
        end
      end
    end
  end

  // ==========================================
  // Register writes, taken on the ack edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_latch <= `GP_RST_LATCH;
      mode_hi    <= `GP_RST_MODE;
      mode_lo    <= `GP_RST_MODE;
      pwm_sel    <= `GP_RST_PWM;
      pwm_lvl    <= `GP_RST_PWM;
    end else if (ack_o && req && we_i && sel_i[0]) begin
      case (adr_i)
        `GP_OFS_LATCH:   port_latch <= dat_i[WIDTH-1:0];
        `GP_OFS_MODE1:   mode_hi    <= dat_i[WIDTH-1:0];
        `GP_OFS_MODE0:   mode_lo    <= dat_i[WIDTH-1:0];
        `GP_OFS_PWM_SEL: pwm_sel    <= dat_i[WIDTH-1:0];
        `GP_OFS_PWM_LVL: pwm_lvl    <= dat_i[WIDTH-1:0];
        default:         port_latch <= port_latch;
      endcase
    end
  end

  assign pwm_act = pwm_sel;

  // ==========================================
  // Per-pin driver cells
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : pins
      gpio_pin_cell u_cell (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .latch_i    (port_latch[g]),
        .mode_i     ({mode_hi[g], mode_lo[g]}),
        .pwm_en_i   (pwm_act[g]),
        .pwm_lvl_i  (pwm_lvl[g]),
        .sense_i    (sensed[g]),
        .very_weak_o(very_weak_o[g]),
        .weak_o     (weak_o[g]),
        .strong_o   (strong_o[g]),
        .pull_down_o(pull_down_o[g]),
        .schmitt_o  (schmitt_o[g])
      );
    end
  endgenerate

endmodule // gpio_pin_drive_modes

`default_nettype wire

/* tb/gpio_checker.sv */
// Purpose: Port assertions for the GPIO drive-mode block
// Assumes: Shadow copies of latch and mode writes
// Notes:   Driver outputs lag a register write by one clock
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pin_map.vh"
module gpio_checker #(
  parameter WIDTH = 8
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [7:0]       adr_i,
  input wire logic [3:0]       sel_i,
  input wire logic [31:0]      dat_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  input wire logic [WIDTH-1:0] very_weak_o,
  input wire logic [WIDTH-1:0] weak_o,
  input wire logic [WIDTH-1:0] strong_o,
  input wire logic [WIDTH-1:0] pull_down_o,
  input wire logic [WIDTH-1:0] schmitt_o
);
  // ==========================================
  // Shadow registers
  logic [WIDTH-1:0] lt, m1, m0, ps, lq, m1q, m0q, psq;
  wire  [WIDTH-1:0] qm = ~m1q & ~m0q & ~psq;
  wire  [WIDTH-1:0] pp = ~m1q & m0q & ~psq;
  wire  [WIDTH-1:0] im = m1q & ~m0q;
  wire  [WIDTH-1:0] od = m1q & m0q & ~psq;
  always @(posedge clk_i) begin
    if (rst_i) begin
      {lt, m1, m0, ps} <= {{WIDTH{1'b1}}, {3*WIDTH{1'b0}}};
    end else if (cyc_i && stb_i && we_i && ack_o && sel_i[0]) begin
      if (adr_i == `GP_OFS_LATCH) lt <= dat_i[WIDTH-1:0];
      if (adr_i == `GP_OFS_MODE1) m1 <= dat_i[WIDTH-1:0];
      if (adr_i == `GP_OFS_MODE0) m0 <= dat_i[WIDTH-1:0];
      if (adr_i == `GP_OFS_PWM_SEL) ps <= dat_i[WIDTH-1:0];
    end
  end
  always @(posedge clk_i) {lq, m1q, m0q, psq} <= {lt, m1, m0, ps};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence taken_s; $rose(cyc_i && stb_i); endsequence
  sequence ack_s; !ack_o [*3] ##1 ack_o ##1 !ack_o; endsequence
  sequence rise_s; lt[0] && !$past(lt[0]) && !m1[0] && !m0[0] && !ps[0]; endsequence
  sequence burst_s; strong_o[0] [*2] ##1 !strong_o[0]; endsequence
  AST_ACK: assert property (taken_s |-> ack_s)
    else $error("ack latency wrong");
  AST_BURST: assert property (rise_s |=> burst_s)
    else $error("strong burst wrong");
  AST_VWEAK: assert property ((very_weak_o & qm) == (lq & qm))
    else $error("very weak pull-up wrong");
  AST_WEAK: assert property ((weak_o & (im | od | (qm & ~lq))) == '0)
    else $error("weak pull-up wrong");
  AST_PDN: assert property (((pull_down_o ^ ~lq) & (qm | pp | od)) == '0)
    else $error("pull-down wrong");
  AST_PUSH: assert property (((strong_o ^ lq) & pp) == '0)
    else $error("push-pull drive wrong");
  AST_INPUT: assert property (((very_weak_o | strong_o | ~schmitt_o) & im) == '0)
    else $error("input-only pin wrong");
  AST_OPEN: assert property (((very_weak_o | strong_o | pull_down_o & lq) & od) == '0)
    else $error("open-drain pin wrong");
  AST_RDLATCH: assert property (ack_o && !we_i && adr_i == `GP_OFS_LATCH |-> dat_o[7:0] == lt)
    else $error("latch read wrong");
endmodule // gpio_checker
`default_nettype wire

/* tb/pad_load_model.sv */
// Purpose: External circuits loading the eight port pads
// Assumes: Strong device drivers outweigh external resistors
// Notes:   A floating pad toggles every clock
`timescale 1ns/1ns
`default_nettype none
module pad_load_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] very_weak_i,
  input  wire logic [7:0] weak_i,
  input  wire logic [7:0] strong_i,
  input  wire logic [7:0] pull_down_i,
  input  wire logic [7:0] sink_i,
  input  wire logic [7:0] source_i,
  output logic      [7:0] pad_o
);
  // ==========================================
  // Pad level
  logic [7:0] flt = 8'h55;
  always @(posedge clk_i) flt <= ~flt;
  assign pad_o = ~pull_down_i & (strong_i | ~sink_i & (very_weak_i | weak_i | source_i | flt));
endmodule // pad_load_model
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the GPIO drive-mode block
// Assumes: 20 MHz clock, pads loaded by pad_load_model
// Notes:   Read data is checked from a queue of expected values
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pin_map.vh"
module testbench;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00, pin_i, very_weak_o, weak_o, strong_o, pull_down_o, schmitt_o;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, rnd = 32'h96dc;
  logic        ack_o, err_o;
  logic [7:0]  sink = 8'h01, src = 8'h00, v, expq[$];
  int          n_errors = 0, num_checks = 0, i, k;
  always #25 clk_i = ~clk_i;
  gpio_pin_drive_modes #(.WIDTH(8)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .err_o(), .pin_i, .very_weak_o, .weak_o, .strong_o,
    .pull_down_o, .schmitt_o);
  pad_load_model pads (.clk_i, .very_weak_i(very_weak_o), .weak_i(weak_o), .strong_i(strong_o),
    .pull_down_i(pull_down_o), .sink_i(sink), .source_i(src), .pad_o(pin_i));
  // ==========================================
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w) expq.push_back(d);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, 24'h00_0000, d, 4'h1};
    for (i = 0; i < 20 && !ack_o; i++) @(posedge clk_i);
    {cyc_i, stb_i} <= 2'b00;
    if (i == 20) begin
      n_errors++;
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) if (ack_o && !we_i) chk(dat_o[7:0], expq.pop_front(), "read");
  // ==========================================
  // Scenarios
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (7) @(posedge clk_i);
    chk(very_weak_o, 8'hff, "reset very weak");
    chk(weak_o, 8'hfe, "weak against load");
    wb(0, `GP_OFS_LATCH, 8'hff);
    wb(0, `GP_OFS_MODE1, 8'h00);
    $display("test reset done");
    wb(1, `GP_OFS_LATCH, 8'h00);
    wb(1, `GP_OFS_LATCH, 8'hff);
    repeat (4) begin
      rnd = lfsr(rnd);
      sink <= rnd[15:8];
      wb(1, `GP_OFS_LATCH, rnd[7:0]);
      repeat (10) @(posedge clk_i);
      chk(pull_down_o, ~rnd[7:0], "quasi pull-down");
      chk(weak_o, rnd[7:0] & ~sink, "quasi weak");
      wb(0, `GP_OFS_PINS, rnd[7:0] & ~sink);
    end
    $display("test quasi done");
    {sink, src} <= 16'h00ff;
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      v = rnd[7:0];
      wb(1, `GP_OFS_MODE1, {8{k[1]}});
      wb(1, `GP_OFS_MODE0, {8{k[0]}});
      wb(1, `GP_OFS_LATCH, v);
      repeat (10) @(posedge clk_i);
      chk(pull_down_o, k == 2 ? 8'h00 : ~v, "pull-down");
      chk(strong_o, k == 1 ? v : 8'h00, "strong");
      wb(0, `GP_OFS_PINS, k == 2 ? 8'hff : v);
      wb(0, `GP_OFS_MODE0, {8{k[0]}});
    end
    wb(1, `GP_OFS_MODE1, 8'h00);
    wb(1, `GP_OFS_MODE0, 8'h00);
    wb(1, `GP_OFS_PWM_LVL, 8'h0f);
    wb(1, `GP_OFS_PWM_SEL, 8'hff);
    repeat (10) @(posedge clk_i);
    chk(strong_o, 8'h0f, "pwm strong");
    chk(pull_down_o, 8'hf0, "pwm pull-down");
    wb(1, `GP_OFS_PWM_SEL, 8'h00);
    wb(1, 8'h18, 8'h5a);
    wb(0, 8'h18, 8'h00);
    $display("test modes done");
    tally_and_finish();
  end
endmodule // testbench
bind gpio_pin_drive_modes gpio_checker #(.WIDTH(WIDTH)) chk_u (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .very_weak_o, .weak_o, .strong_o,
  .pull_down_o, .schmitt_o);
`default_nettype wire
